// File: hdl/dsb_conv_top.sv
// dsb_conv_top: sequencing of a dual-slope converter with multiplexed bcd scan.
// assumes analog comparator and rate-level detectors arrive asynchronously
// and an external decoder latches each digit from the inverted selects.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - all timing from internal 786 Hz oscillator; here only the digit scan uses it, sampling and steps count mclk
// - rate input high gives 96 Hz sampling
// - rate input low or open gives 4 Hz
// - hold: 4 Hz, display frozen at last result
// - after hold, display updates, rate stays slow
// - fixed integrate, then switch to reference
// - count de-integrate steps, latch on comparator
// - digits multiplexed with matching digit select
// - conversion takes about 5 ms
// - overrange codes 1010 negative, 1011 positive
// - negative to -99: minus in hundreds
// - positive range up to 999 counts
module dsb_conv_top
    import dsb_pkg::*;
#(
    parameter int OSC_CYC_P = OSC_CYC,
    parameter int FAST_PERIOD_P = FAST_PERIOD_CYC,
    parameter int SLOW_PERIOD_P = SLOW_PERIOD_CYC,
    parameter int STEP_CYC_P = STEP_CYC
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rateHighLvl,
    input wire logic rateHoldLvl,
    input wire logic cmpReturned,
    output logic integrateEn,
    output logic deintegrateEn,
    output logic [3:0] bcdOut,
    output logic digitSelectHundreds_b,
    output logic digitSelectTens_b,
    output logic digitSelectUnits_b
);
    localparam int PER_W = $clog2(SLOW_PERIOD_P + 1);
    localparam int OSC_W = $clog2(OSC_CYC_P + 1);
    localparam int STEP_W = $clog2(STEP_CYC_P + 1);

    // two-flop synchronisers for the asynchronous inputs
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    logic highSync;
    logic holdSync;
    logic cmpSync;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= 3'h0;
            syncB_q <= 3'h0;
        end else begin
            syncA_q <= {rateHighLvl, rateHoldLvl, cmpReturned};
            syncB_q <= syncA_q;
        end
    end
    assign highSync = syncB_q[2];
    assign holdSync = syncB_q[1];
    assign cmpSync = syncB_q[0];

    // sampling period; once hold has been seen the fast rate stays locked out
    logic slowLatch_q;
    logic slowLatch_d;
    logic [PER_W-1:0] perCnt_q;
    logic [PER_W-1:0] perCnt_d;
    logic [PER_W-1:0] periodTerm;
    logic fastSel;
    logic convStart;

    always_comb begin
        slowLatch_d = slowLatch_q | holdSync;
        fastSel = highSync & ~holdSync & ~slowLatch_q;
        periodTerm = fastSel ? PER_W'(FAST_PERIOD_P - 1) : PER_W'(SLOW_PERIOD_P - 1);
        // >= so that a switch to the shorter period never overruns the counter
        convStart = (perCnt_q >= periodTerm);
        perCnt_d = convStart ? '0 : perCnt_q + PER_W'(1);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            slowLatch_q <= 1'b0;
            perCnt_q <= '0;
        end else begin
            slowLatch_q <= slowLatch_d;
            perCnt_q <= perCnt_d;
        end
    end

    // conversion sequencer: fixed integrate, then counted de-integrate
    dsb_state_t state_q;
    dsb_state_t state_d;
    logic [STEP_W-1:0] stepCnt_q;
    logic [STEP_W-1:0] stepCnt_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] result_q;
    logic [CNT_W-1:0] result_d;
    logic loadPend_q;
    logic loadPend_d;
    logic stepTick;

    always_comb begin
        stepTick = (stepCnt_q == STEP_W'(STEP_CYC_P - 1));
        state_d = state_q;
        stepCnt_d = stepTick ? '0 : stepCnt_q + STEP_W'(1);
        count_d = count_q;
        result_d = result_q;
        loadPend_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                stepCnt_d = '0;
                if (convStart) begin
                    state_d = ST_INTEG;
                    count_d = '0;
                end
            end
            ST_INTEG: begin
                if (stepTick) begin
                    if (count_q == CNT_W'(INT_STEPS - 1)) begin
                        state_d = ST_DEINT;
                        count_d = '0;
                    end else begin
                        count_d = count_q + CNT_W'(1);
                    end
                end
            end
            ST_DEINT: begin
                if (stepTick) begin
                    // trip at step zero means beyond the negative range
                    if (cmpSync || count_q == CNT_W'(FULL_STEPS)) begin
                        result_d = count_q;
                        loadPend_d = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        count_d = count_q + CNT_W'(1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            stepCnt_q <= '0;
            count_q <= '0;
            result_q <= '0;
            loadPend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stepCnt_q <= stepCnt_d;
            count_q <= count_d;
            result_q <= result_d;
            loadPend_q <= loadPend_d;
        end
    end

    // analog switch controls, decoded from the state flop
    assign integrateEn = (state_q == ST_INTEG);
    assign deintegrateEn = (state_q == ST_DEINT);

    // display latch: hold keeps the last reading taken before it
    logic [3:0] encHund;
    logic [3:0] encTens;
    logic [3:0] encUnits;
    logic [3:0] dispHund_q;
    logic [3:0] dispTens_q;
    logic [3:0] dispUnits_q;
    logic [3:0] dispHund_d;
    logic [3:0] dispTens_d;
    logic [3:0] dispUnits_d;

    dsb_digit_enc u_enc (
        .count(result_q),
        .hundCode(encHund),
        .tensCode(encTens),
        .unitsCode(encUnits)
    );

    always_comb begin
        dispHund_d = dispHund_q;
        dispTens_d = dispTens_q;
        dispUnits_d = dispUnits_q;
        if (loadPend_q && !holdSync) begin
            dispHund_d = encHund;
            dispTens_d = encTens;
            dispUnits_d = encUnits;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dispHund_q <= BCD_RST;
            dispTens_q <= BCD_RST;
            dispUnits_q <= BCD_RST;
        end else begin
            dispHund_q <= dispHund_d;
            dispTens_q <= dispTens_d;
            dispUnits_q <= dispUnits_d;
        end
    end

    // digit scan paced by the 786 Hz oscillator tick
    logic [OSC_W-1:0] oscCnt_q;
    logic [OSC_W-1:0] oscCnt_d;
    logic oscTick;
    dsb_digit_t digit_q;
    dsb_digit_t digit_d;
    logic [3:0] bcd_q;
    logic [3:0] bcd_d;
    logic [2:0] sel_q;
    logic [2:0] sel_d;

    always_comb begin
        oscTick = (oscCnt_q == OSC_W'(OSC_CYC_P - 1));
        oscCnt_d = oscTick ? '0 : oscCnt_q + OSC_W'(1);
        digit_d = digit_q;
        if (oscTick) begin
            unique case (digit_q)
                DG_HUND: digit_d = DG_TENS;
                DG_TENS: digit_d = DG_UNITS;
                DG_UNITS: digit_d = DG_HUND;
                default: digit_d = DG_HUND;
            endcase
        end
        // mux from next display value so bcd and select never disagree
        unique case (digit_d)
            DG_HUND: begin
                bcd_d = dispHund_d;
                sel_d = SEL_HUND;
            end
            DG_TENS: begin
                bcd_d = dispTens_d;
                sel_d = SEL_TENS;
            end
            default: begin
                bcd_d = dispUnits_d;
                sel_d = SEL_UNITS;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oscCnt_q <= '0;
            digit_q <= DG_HUND;
            bcd_q <= BCD_RST;
            sel_q <= SEL_HUND;
        end else begin
            oscCnt_q <= oscCnt_d;
            digit_q <= digit_d;
            bcd_q <= bcd_d;
            sel_q <= sel_d;
        end
    end

    assign bcdOut = bcd_q;
    assign digitSelectHundreds_b = sel_q[2];
    assign digitSelectTens_b = sel_q[1];
    assign digitSelectUnits_b = sel_q[0];

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_integLast;
        state_q == ST_INTEG && stepTick && count_q == CNT_W'(INT_STEPS - 1);
    endsequence
    sequence s_deintFirst;
        state_q == ST_DEINT && count_q == '0 && stepCnt_q == '0;
    endsequence

    property p_oneSelect;
        $onehot(~sel_q);
    endproperty
    a_oneSelect: assert property (p_oneSelect) else $error("digit select not one-hot");

    property p_scanOnTick;
        $changed(sel_q) |-> $past(oscTick);
    endproperty
    a_scanOnTick: assert property (p_scanOnTick) else $error("scan moved without oscillator tick");

    property p_integToDeint;
        s_integLast |=> s_deintFirst ##0 (deintegrateEn && !integrateEn);
    endproperty
    a_integToDeint: assert property (p_integToDeint) else $error("integrate end did not switch to reference");

    property p_latchCount;
        (state_q == ST_DEINT && stepTick && cmpSync) |=> state_q == ST_IDLE && loadPend_q
            && result_q == $past(count_q);
    endproperty
    a_latchCount: assert property (p_latchCount) else $error("count not latched on comparator");

    property p_bcdMatchesSel;
        !digitSelectTens_b |-> bcdOut == dispTens_q;
    endproperty
    a_bcdMatchesSel: assert property (p_bcdMatchesSel) else $error("bcd does not match tens select");

    property p_holdFreeze;
        (holdSync && $past(holdSync)) |-> $stable(dispHund_q) && $stable(dispTens_q) && $stable(dispUnits_q);
    endproperty
    a_holdFreeze: assert property (p_holdFreeze) else $error("display changed in hold");

    property p_slowAfterHold;
        (slowLatch_q && convStart) |-> perCnt_q == PER_W'(SLOW_PERIOD_P - 1);
    endproperty
    a_slowAfterHold: assert property (p_slowAfterHold) else $error("fast rate after hold");

    property p_fastRate;
        (highSync && !holdSync && !slowLatch_q) |-> periodTerm == PER_W'(FAST_PERIOD_P - 1);
    endproperty
    a_fastRate: assert property (p_fastRate) else $error("fast period not selected");

    property p_slowRate;
        !highSync |-> periodTerm == PER_W'(SLOW_PERIOD_P - 1);
    endproperty
    a_slowRate: assert property (p_slowRate) else $error("slow period not selected");

    property p_overCodes;
        (result_q == '0 |-> encUnits == CODE_MINUS && encHund == CODE_MINUS)
        and (result_q >= CNT_W'(FULL_STEPS) |-> encUnits == CODE_OVER_POS && encTens == CODE_OVER_POS);
    endproperty
    a_overCodes: assert property (p_overCodes) else $error("overrange code wrong");

    property p_minusSign;
        (result_q != '0 && result_q < CNT_W'(ZERO_OFS)) |-> encHund == CODE_MINUS && encTens <= 4'h9;
    endproperty
    a_minusSign: assert property (p_minusSign) else $error("negative reading without minus");

    property p_posRange;
        (result_q >= CNT_W'(ZERO_OFS) && result_q < CNT_W'(FULL_STEPS)) |-> encHund <= 4'h9 && encUnits <= 4'h9;
    endproperty
    a_posRange: assert property (p_posRange) else $error("in-range reading not bcd");

    property p_deintBound;
        state_q == ST_DEINT |-> count_q <= CNT_W'(FULL_STEPS);
    endproperty
    a_deintBound: assert property (p_deintBound) else $error("de-integrate ran past full scale");
endmodule

`default_nettype wire

// File: inc/dsb_pkg.sv
// dsb_pkg: constants and types for the dual-slope converter sequencer.
// assumes a 100 MHz mclk; every time here is turned into cycles of it.
`default_nettype none

package dsb_pkg;
    // clock and internal oscillator
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_FREQ_HZ = 786;
    localparam int OSC_CYC = 1_000_000_000 / (OSC_FREQ_HZ * CLK_PERIOD_NS);
    // sampling rates, periods rounded down to whole cycles
    localparam int FAST_RATE_HZ = 96;
    localparam int SLOW_RATE_HZ = 4;
    localparam int FAST_PERIOD_CYC = 1_000_000_000 / (FAST_RATE_HZ * CLK_PERIOD_NS);
    localparam int SLOW_PERIOD_CYC = 1_000_000_000 / (SLOW_RATE_HZ * CLK_PERIOD_NS);
    // conversion: integrate and de-integrate each up to FULL_STEPS count steps
    localparam int CONV_TIME_NS = 5_000_000;
    localparam int ZERO_OFS = 100;
    localparam int FULL_SCALE = 999;
    localparam int FULL_STEPS = ZERO_OFS + FULL_SCALE + 1;
    localparam int INT_STEPS = FULL_STEPS;
    localparam int STEP_CYC = CONV_TIME_NS / (CLK_PERIOD_NS * 2 * FULL_STEPS);
    localparam int CNT_W = 11;
    // display codes and reset values
    localparam logic [3:0] CODE_MINUS = 4'ha;
    localparam logic [3:0] CODE_OVER_POS = 4'hb;
    localparam logic [3:0] BCD_RST = 4'h0;
    // digit selects, active low, ordered {hundreds, tens, units}
    localparam logic [2:0] SEL_HUND = 3'h3;
    localparam logic [2:0] SEL_TENS = 3'h5;
    localparam logic [2:0] SEL_UNITS = 3'h6;

    typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_DEINT} dsb_state_t;
    typedef enum logic [1:0] {DG_HUND, DG_TENS, DG_UNITS} dsb_digit_t;
endpackage

`default_nettype wire

// File: hdl/dsb_digit_enc.sv
// dsb_digit_enc: turns a latched de-integrate count into three display codes.
// assumes count runs 0..FULL_STEPS with ZERO_OFS counts meaning zero volts.
`timescale 1ns/1ps
`default_nettype none

module dsb_digit_enc
    import dsb_pkg::*;
(
    input wire logic [CNT_W-1:0] count,
    output logic [3:0] hundCode,
    output logic [3:0] tensCode,
    output logic [3:0] unitsCode
);
    logic [CNT_W-1:0] mag;
    logic [CNT_W-1:0] hq;
    logic [CNT_W-1:0] tq;
    logic [CNT_W-1:0] uq;

    // sign, overrange and magnitude split; constant divisors keep this small
    always_comb begin
        mag = '0;
        if (count < CNT_W'(ZERO_OFS)) begin
            mag = CNT_W'(ZERO_OFS) - count;
        end else begin
            mag = count - CNT_W'(ZERO_OFS);
        end
        hq = mag / CNT_W'(100);
        tq = (mag / CNT_W'(10)) % CNT_W'(10);
        uq = mag % CNT_W'(10);
        hundCode = hq[3:0];
        tensCode = tq[3:0];
        unitsCode = uq[3:0];
        if (count == '0) begin
            // below -99: dashes in every digit
            hundCode = CODE_MINUS;
            tensCode = CODE_MINUS;
            unitsCode = CODE_MINUS;
        end else if (count < CNT_W'(ZERO_OFS)) begin
            hundCode = CODE_MINUS;
        end else if (count >= CNT_W'(FULL_STEPS)) begin
            hundCode = CODE_OVER_POS;
            tensCode = CODE_OVER_POS;
            unitsCode = CODE_OVER_POS;
        end
    end
endmodule

`default_nettype wire

// File: dv/dsb_dec_model.sv
// dsb_dec_model: per-digit latching bcd decoder on the display side.
// assumes active-low digit selects; the inverted select is each latch strobe.
`timescale 1ns/1ps
`default_nettype none

module dsb_dec_model (
    input wire logic mclk,
    input wire logic [3:0] bcdOut,
    input wire logic digitSelectHundreds_b,
    input wire logic digitSelectTens_b,
    input wire logic digitSelectUnits_b,
    output logic [11:0] shown
);
    // a digit follows the bus only while its own select is low, then holds
    always_ff @(posedge mclk) begin
        if (!digitSelectHundreds_b) shown[11:8] <= bcdOut;
        if (!digitSelectTens_b) shown[7:4] <= bcdOut;
        if (!digitSelectUnits_b) shown[3:0] <= bcdOut;
    end
endmodule

`default_nettype wire

// File: dv/test_dual_slope_bcd_display_scan.sv
// test_dual_slope_bcd_display_scan: self-checking bench for dsb_conv_top.
// assumes shortened counts; the bench plays the comparator and rate pin.
`timescale 1ns/1ps
`default_nettype none

module test_dual_slope_bcd_display_scan
    import dsb_pkg::*;
;
    localparam int OSC_P = 8;
    localparam int FAST_P = 3000;
    localparam int SLOW_P = 6000;
    localparam int STEP_P = 1;
    localparam int LIMIT = 90000;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic rateHighLvl = 1'b1;
    logic rateHoldLvl = 1'b0;
    logic cmpReturned = 1'b0;
    logic integrateEn, deintegrateEn, hundB, tensB, unitsB;
    logic [3:0] bcdOut;
    logic [11:0] shown;
    logic [11:0] shownExp = 12'h0;
    logic [2:0] selPrev = SEL_HUND;
    logic dispOk = 1'b0;
    logic scanSeen = 1'b0;
    int errCount = 0, nCompared = 0, cyc = 0, lastStart = 0;
    int nRes = 0, holdCnt = 0, seed = 32'h94c2;
    int tg[8] = '{-1, 5, 60, 99, 100, 623, 1098, 5000};
    wire logic [2:0] sel = {hundB, tensB, unitsB};

    dsb_conv_top #(.OSC_CYC_P(OSC_P), .FAST_PERIOD_P(FAST_P), .SLOW_PERIOD_P(SLOW_P),
        .STEP_CYC_P(STEP_P)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .rateHighLvl(rateHighLvl), .rateHoldLvl(rateHoldLvl),
        .cmpReturned(cmpReturned), .integrateEn(integrateEn), .deintegrateEn(deintegrateEn),
        .bcdOut(bcdOut), .digitSelectHundreds_b(hundB), .digitSelectTens_b(tensB),
        .digitSelectUnits_b(unitsB)
    );

    dsb_dec_model i_dec (
        .mclk(mclk), .bcdOut(bcdOut), .digitSelectHundreds_b(hundB),
        .digitSelectTens_b(tensB), .digitSelectUnits_b(unitsB), .shown(shown)
    );

    // free-running 100 MHz clock
    always #5 mclk = ~mclk;

    task automatic stopTest();
        $display("errors %0d compared %0d", errCount, nCompared);
        if (errCount == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // reference digits; count 100 stands for zero volts
    function automatic logic [11:0] expDigits(input int n);
        int v;
        if (n <= 0) return 12'haaa;
        if (n >= 1100) return 12'hbbb;
        if (n < 100) begin
            v = 100 - n;
            return {4'ha, 4'(v / 10), 4'(v % 10)};
        end
        v = n - 100;
        return {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    // one conversion: tgt<0 trips early, a huge tgt never trips
    task automatic conv(input int tgt, input int per);
        int w;
        int d;
        w = 0;
        while (integrateEn !== 1'b1 && w < 7000) begin
            @(posedge mclk);
            w++;
        end
        if (per > 0) check(cyc - lastStart, per);
        lastStart = cyc;
        if (tgt < 0) cmpReturned <= 1'b1;
        w = 0;
        while (integrateEn === 1'b1) begin
            @(posedge mclk);
            w++;
        end
        check(w, INT_STEPS * STEP_P);
        dispOk = 1'b0;
        d = 0;
        while (deintegrateEn === 1'b1 && d < 1200) begin
            if (d == tgt) cmpReturned <= 1'b1;
            @(posedge mclk);
            d++;
        end
        cmpReturned <= 1'b0;
        // the last de-integrate cycle, index d-1, comes three steps after the comparator is raised
        nRes = (d > 1101) ? 1100 : d - 1;
        repeat (40) @(posedge mclk);
    endtask

    task automatic show(input logic frozen);
        if (!frozen) shownExp = expDigits(nRes);
        check(shown, shownExp);
        dispOk = 1'b1;
    endtask

    // scan watcher, pairing of data and select, and hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        // the hang limit ends the run, so nothing else may follow it in this process
        if (cyc == LIMIT) begin
            errCount++;
            stopTest();
        end else if (rst_b === 1'b1) begin
            check(sel === SEL_HUND || sel === SEL_TENS || sel === SEL_UNITS, 1);
            if (sel !== selPrev) begin
                if (scanSeen) check(holdCnt, OSC_P);
                check(sel, selPrev === SEL_HUND ? SEL_TENS : selPrev === SEL_TENS ? SEL_UNITS : SEL_HUND);
                scanSeen = 1'b1;
                holdCnt = 0;
                selPrev = sel;
            end
            holdCnt++;
            if (dispOk)
                check(bcdOut, sel === SEL_HUND ? shownExp[11:8] : sel === SEL_TENS ? shownExp[7:4] : shownExp[3:0]);
        end
    end

    // main sequence: fast readings, slow, hold, and release of hold
    initial begin
        repeat (5) @(posedge mclk);
        check({integrateEn, deintegrateEn, bcdOut, sel}, {2'h0, BCD_RST, SEL_HUND});
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            conv(tg[i], i > 0 ? FAST_P : 0);
            show(1'b0);
        end
        repeat (2) begin
            conv($random(seed) & 32'h3ff, FAST_P);
            show(1'b0);
        end
        rateHighLvl <= 1'b0;
        conv(300, 0);
        show(1'b0);
        conv(450, SLOW_P);
        show(1'b0);
        rateHoldLvl <= 1'b1;
        conv(700, SLOW_P);
        show(1'b1);
        conv(800, SLOW_P);
        show(1'b1);
        rateHoldLvl <= 1'b0;
        rateHighLvl <= 1'b1;
        conv(900, SLOW_P);
        show(1'b0);
        conv(200, SLOW_P);
        show(1'b0);
        stopTest();
    end
endmodule

`default_nettype wire
